// File: bench/core_model.sv
// Behavioural model of the processor core taking interrupt offers
`timescale 1ns/1ps
module core_model import irq_pkg::*; (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Offer and acknowledge
   input  wire accept_req_s accept,
   output logic             core_ack,
   // Bench control
   input  wire logic        enable,
   input  wire logic [3:0]  delay
);
   logic [3:0] wait_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // One pulse per standing offer; a slow core lets the offer age first
   always_ff @(posedge clk) begin
      if (rst) begin
         core_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else begin
         core_ack <= 1'b0;
         if (enable && accept.valid && !core_ack) begin
            if (wait_cnt >= delay) begin
               core_ack <= 1'b1;
               wait_cnt <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end else begin
            wait_cnt <= 4'h0;
         end
      end
   end
endmodule // core_model

// File: bench/irq_flags_and_priority_unit_tb.sv
// Self-checking bench of the interrupt flag and priority unit
`timescale 1ns/1ps
module irq_flags_and_priority_unit_tb import irq_pkg::*; ;
   typedef struct packed {
      logic [7:0]  ofs;
      logic [31:0] wdata;
      logic [31:0] exp;
   } row_s;
   localparam row_s ROWS [11] = '{
      '{OFS_PRI_BASE, 32'h0000_0052, 32'h0000_0052},
      '{OFS_PRI_BASE + 8'h04, 32'h0000_0077, 32'h0000_0077},
      '{OFS_PRI_BASE + 8'h08, 32'h0000_0033, 32'h0000_0033},
      '{OFS_PRI_BASE + 8'h0C, 32'h0000_0007, 32'h0000_0007},
      '{OFS_PRI_BASE + 8'h10, 32'h0000_0070, 32'h0000_0070},
      '{OFS_PRI_BASE + 8'h14, 32'h0000_0075, 32'h0000_0075},
      '{OFS_FLAGS, 32'h0000_00FF, 32'(FLAGS_ONES)},
      '{OFS_PIN_EN, 32'h0000_00FF, 32'h0000_000E},
      '{OFS_XFER_HI, 32'hFFFF_FFFF, 32'h0000_03FF},
      '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000},
      '{OFS_CORE_SR, 32'h0000_0083, 32'h0000_0083}};

   logic                    clk;
   logic                    rst;
   logic                    hsel;
   logic [31:0]             haddr;
   logic [1:0]              htrans;
   logic                    hwrite;
   logic [2:0]              hsize;
   logic [31:0]             hwdata;
   logic [31:0]             hrdata;
   logic                    hreadyout;
   logic                    hresp;
   logic [NUM_PINS-1:0]     pin_irq_n;
   logic [NUM_INTERNAL-1:0] internal_req;
   accept_req_s             accept;
   logic                    core_ack;
   logic                    xfer_start;
   logic [LVL_W-1:0]        sr_mask_level;
   logic                    sr_trace;
   logic                    irq;
   logic                    core_en;
   logic [3:0]              core_delay;
   logic [31:0]             rd;
   int                      mismatches = 0;
   int                      check_count = 0;
   int                      n;

   irq_flags_and_priority_unit irq_flags_and_priority_unit_i (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pin_irq_n(pin_irq_n), .internal_req(internal_req), .accept(accept),
      .core_ack(core_ack), .xfer_start(xfer_start),
      .sr_mask_level(sr_mask_level), .sr_trace(sr_trace), .irq(irq));

   core_model core_model_i (
      .clk(clk), .rst(rst), .accept(accept), .core_ack(core_ack),
      .enable(core_en), .delay(core_delay));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Sampling right after the edge sees the values the slave drove before it
   task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, ofs};
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp, input string msg);
      ahb(1'b0, ofs, 32'h0000_0000);
      check(rd, exp, msg);
      check(32'(hresp), 32'h0000_0000, "response not OKAY");
   endtask

   task automatic wait_ack();
      for (n = 0; n < 64 && core_ack !== 1'b1; n++) @(posedge clk);
      check(core_ack, 1'b1, "no acknowledge");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      pin_irq_n = '1;
      internal_req = '0;
      core_en = 1'b0;
      core_delay = 4'h0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < NUM_PRI; i++) begin
         rchk(OFS_PRI_BASE + 8'(4 * i), 32'(PRI_RESET), "priority reset");
      end
      rchk(OFS_FLAGS, 32'(FLAGS_ONES), "flag reset");
      foreach (ROWS[i]) begin
         ahb(1'b1, ROWS[i].ofs, ROWS[i].wdata);
         rchk(ROWS[i].ofs, ROWS[i].exp, "register row");
      end
      // Level 4 source against mask 3, then against an equal mask
      ahb(1'b1, OFS_PRI_BASE + 8'h04, 32'h0000_0040);
      core_en <= 1'b1;
      internal_req[2] <= 1'b1;
      wait_ack();
      check(32'(accept.idx), 32'd5, "source index");
      check(32'(accept.level), 32'd4, "offer level");
      @(posedge clk);
      check(32'(sr_mask_level), 32'd4, "mask load");
      check(sr_trace, 1'b0, "trace clear");
      repeat (12) @(posedge clk);
      check(accept.valid, 1'b0, "equal level offered");
      ahb(1'b1, OFS_CORE_SR, 32'h0000_0003);
      wait_ack();
      // Same source routed to the transfer controller
      ahb(1'b1, OFS_XFER_LO, 32'h0000_0020);
      ahb(1'b1, OFS_CORE_SR, 32'h0000_0000);
      for (n = 0; n < 64 && xfer_start !== 1'b1; n++) @(posedge clk);
      check(xfer_start, 1'b1, "transfer start");
      check(32'(sr_mask_level), 32'd0, "mask kept");
      internal_req <= '0;
      ahb(1'b1, OFS_XFER_LO, 32'h0000_0000);
      // Pin flags with the core held off, then a slow core
      core_en <= 1'b0;
      ahb(1'b1, OFS_PRI_BASE, 32'h0000_0005);
      pin_irq_n[1] <= 1'b0;
      repeat (10) @(posedge clk);
      ahb(1'b1, OFS_FLAGS, 32'h0000_0000);
      rchk(OFS_FLAGS, 32'(FLAGS_ONES) | 32'h0000_0004, "flag set, unarmed clear");
      ahb(1'b1, OFS_FLAGS, 32'h0000_0000);
      rchk(OFS_FLAGS, 32'(FLAGS_ONES), "software clear");
      pin_irq_n[1] <= 1'b1;
      pin_irq_n[0] <= 1'b0;
      core_delay <= 4'h3;
      core_en <= 1'b1;
      wait_ack();
      check(32'(accept.idx), 32'd0, "pin index");
      check(32'(accept.level), 32'd5, "pin group level");
      pin_irq_n[0] <= 1'b1;
      rchk(OFS_FLAGS, 32'(FLAGS_ONES), "flag clear on accept");
      // Event interrupt: masked, unmasked, cleared by read
      check(irq, 1'b0, "masked event");
      ahb(1'b1, OFS_EV_MASK, 32'h0000_0004);
      @(posedge clk);
      check(irq, 1'b1, "unmasked event");
      rchk(OFS_EV_STATUS, 32'h0000_0007, "event status");
      @(posedge clk);
      check(irq, 1'b0, "event cleared");
      // Mid-run reset while the priority registers hold nonzero levels
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < NUM_PRI; i++) begin
         rchk(OFS_PRI_BASE + 8'(4 * i), 32'(PRI_RESET), "priority after reset");
      end
      rchk(OFS_FLAGS, 32'(FLAGS_ONES), "flags after reset");
      close_out();
   end
endmodule // irq_flags_and_priority_unit_tb

// File: rtl/irq_flags_and_priority_unit.sv
// Pin request flags, priority registers and two-cycle priority decision
//
// What this block does
// R01: Pin request sets its flag bit
// R02: Core acceptance clears the matching pin flag
// R03: Read one then write zero clears flag
// R04: Flag register bit 0 always reads one
// R05: Thirty-nine internal sources, each own vector
// R06: Transfer-enable bit routes acceptance to transfer controller
// R07: Acceptance not routed to the transfer controller clears trace, loads mask level
// R08: Six priority registers, reset to zero
// R09: Software keeps upper bit 7 zero
// R10: Software keeps lower bit 3 zero
// R11: Each priority register serves two modules
// R12: Level field is unsigned binary zero-seven
// R13: Sixth register: serial channel one, two/three
// R14: Priority decision takes two clock cycles
// R15: Enabled pins request on falling edge
// R16: First register: watchdog group, pins one-three
// R17: Accept only level strictly above mask
// R18: Writes to reserved bits are ignored
`timescale 1ns/1ps
module irq_flags_and_priority_unit import irq_pkg::*; (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic                    hready,
   input  wire logic [31:0]             hwdata,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // Request pins and peripheral sources
   input  wire logic [NUM_PINS-1:0]     pin_irq_n,
   input  wire logic [NUM_INTERNAL-1:0] internal_req,
   // Core handshake
   output accept_req_s                  accept,
   input  wire logic                    core_ack,
   output logic                         xfer_start,
   output logic [LVL_W-1:0]             sr_mask_level,
   output logic                         sr_trace,
   // Event interrupt
   output logic                         irq
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [NUM_PINS-1:0]     pin_flag;
   logic [NUM_PINS-1:0]     pin_armed;
   logic [NUM_PINS-1:0]     pin_en;
   logic [LVL_W-1:0]        pri_field [NUM_FIELDS];
   logic [NUM_SRC-1:0]      xfer_en;
   logic [EV_W-1:0]         ev_status;
   logic [EV_W-1:0]         ev_mask;
   bus_state_e              bus_state;
   logic [7:0]              dp_addr;
   logic [1:0]              holdoff;
   logic [NUM_SRC-1:0]      pend_q;
   logic [LVL_W-1:0]        lvl_q [NUM_SRC];

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode
   wire logic               ap_take  = hsel & htrans[1] & hready;
   wire logic               wr_now   = (bus_state == BUS_WRITE);
   wire logic               rd_now   = (bus_state == BUS_READ_WAIT);
   wire logic               wr_flags = wr_now & (dp_addr == OFS_FLAGS);
   wire logic               rd_flags = rd_now & (dp_addr == OFS_FLAGS);
   wire logic               rd_ev    = rd_now & (dp_addr == OFS_EV_STATUS);
   wire logic [7:0]         wr_byte  = hwdata[7:0];
   wire logic [7:0]         pri_rel  = dp_addr - OFS_PRI_BASE;
   wire logic               pri_hit  = (dp_addr >= OFS_PRI_BASE) && (pri_rel[1:0] == 2'b00)
                                       && (pri_rel[7:2] < 6'(NUM_PRI));
   wire logic [2:0]         pri_sel  = pri_rel[4:2];

   // Wait state on reads: the value is sampled after any write in flight lands
   assign hreadyout = (bus_state != BUS_READ_WAIT);
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_state <= BUS_IDLE;
         dp_addr   <= 8'h00;
      end else if (rd_now) begin
         bus_state <= BUS_READ_DONE;
      end else begin
         bus_state <= !ap_take ? BUS_IDLE : (hwrite ? BUS_WRITE : BUS_READ_WAIT);
         dp_addr   <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin edges and request flags
   logic [NUM_PINS-1:0]     pin_fall;
   logic [NUM_PINS-1:0]     pin_set;
   logic [NUM_PINS-1:0]     clr_auto;
   logic [NUM_PINS-1:0]     clr_sw;

   pin_fall_detect #(.N(NUM_PINS)) pin_fall_detect_i (
      .clk   (clk),
      .rst   (rst),
      .pin_n (pin_irq_n),
      .fall  (pin_fall)
   );

   wire logic               ack_take = core_ack & accept.valid;
   assign pin_set  = pin_fall & pin_en;                                             // R15
   assign clr_sw   = {NUM_PINS{wr_flags}} & pin_armed
                     & ~wr_byte[FLAG_LSB +: NUM_PINS];                              // R03

   genvar p;
   generate
      for (p = 0; p < NUM_PINS; p++) begin : g_flag
         assign clr_auto[p] = ack_take & (accept.idx == IDX_W'(p));                 // R02
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_flag  <= '0;
         pin_armed <= '0;
      end else begin
         // Set wins over any clear; writing one sets nothing
         pin_flag  <= pin_set | (pin_flag & ~clr_auto & ~clr_sw);                   // R01 R03
         // Acceptance disarms too, so a later edge needs a fresh read before a clear
         pin_armed <= (rd_flags ? pin_flag : pin_armed) & pin_flag & ~clr_sw & ~clr_auto; // R03
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_en  <= '0;
         xfer_en <= '0;
         ev_mask <= '0;
      end else if (wr_now) begin
         if (dp_addr == OFS_PIN_EN) begin
            pin_en <= wr_byte[FLAG_LSB +: NUM_PINS];
         end
         if (dp_addr == OFS_XFER_LO) begin
            xfer_en[31:0] <= hwdata;
         end
         if (dp_addr == OFS_XFER_HI) begin
            xfer_en[NUM_SRC-1:32] <= hwdata[XFER_HI_W-1:0];
         end
         if (dp_addr == OFS_EV_MASK) begin
            ev_mask <= hwdata[EV_W-1:0];
         end
      end
   end

   // Bits 7 and 3 are never stored, so they read back as zero
   genvar f;
   generate
      for (f = 0; f < NUM_FIELDS; f++) begin : g_pri
         localparam int LSB = (f % 2 == 0) ? PRI_UPPER_LSB : PRI_LOWER_LSB;
         always_ff @(posedge clk) begin
            if (rst) begin
               pri_field[f] <= PRI_RESET[LSB +: LVL_W];                             // R08
            end else if (wr_now && pri_hit && pri_sel == 3'(f / 2)) begin
               pri_field[f] <= wr_byte[LSB +: LVL_W];                               // R11 R18
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Read data
   logic [31:0] rd_value;

   always_comb begin
      rd_value = 32'h0000_0000;
      if (dp_addr == OFS_FLAGS) begin
         rd_value[7:0] = FLAGS_ONES | 8'({pin_flag, 1'b0});                         // R04
      end else if (pri_hit) begin
         rd_value[7:0] = {1'b0, pri_field[2*pri_sel], 1'b0, pri_field[2*pri_sel+1]};
      end else if (dp_addr == OFS_PIN_EN) begin
         rd_value[7:0] = 8'({pin_en, 1'b0});
      end else if (dp_addr == OFS_XFER_LO) begin
         rd_value = xfer_en[31:0];
      end else if (dp_addr == OFS_XFER_HI) begin
         rd_value[XFER_HI_W-1:0] = xfer_en[NUM_SRC-1:32];
      end else if (dp_addr == OFS_CORE_SR) begin
         rd_value[SR_TRACE_BIT] = sr_trace;
         rd_value[SR_MASK_LSB +: LVL_W] = sr_mask_level;
      end else if (dp_addr == OFS_EV_STATUS) begin
         rd_value[EV_W-1:0] = ev_status;
      end else if (dp_addr == OFS_EV_MASK) begin
         rd_value[EV_W-1:0] = ev_mask;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_now) begin
         hrdata <= rd_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Priority decision, stage one: snapshot pending sources and their levels
   wire logic [NUM_SRC-1:0] pend_raw = {internal_req, pin_flag};                    // R05

   genvar s;
   generate
      for (s = 0; s < NUM_SRC; s++) begin : g_src
         always_ff @(posedge clk) begin
            if (rst) begin
               lvl_q[s] <= '0;
            end else begin
               lvl_q[s] <= pri_field[field_of(s)];                                  // R12 R13 R16
            end
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         pend_q <= '0;
      end else begin
         pend_q <= pend_raw;                                                        // R14
      end
   end

   // Stage two: highest level wins, lowest index breaks a tie
   logic             best_hit;
   logic [IDX_W-1:0] best_idx;
   logic [LVL_W-1:0] best_lvl;

   always_comb begin
      best_hit = 1'b0;
      best_idx = '0;
      best_lvl = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (pend_q[i] && (!best_hit || lvl_q[i] > best_lvl)) begin
            best_hit = 1'b1;
            best_idx = IDX_W'(i);
            best_lvl = lvl_q[i];
         end
      end
   end

   // Holdoff lets the pipeline see the cleared source before offering again
   wire logic offer = best_hit && (best_lvl > sr_mask_level) && (holdoff == 2'd0)
                      && !ack_take;                                                 // R17

   always_ff @(posedge clk) begin
      if (rst) begin
         accept  <= '0;
         holdoff <= '0;
      end else begin
         accept.valid   <= offer;                                                   // R14
         accept.idx     <= best_idx;
         accept.level   <= best_lvl;
         accept.to_xfer <= xfer_en[best_idx];                                       // R06
         holdoff        <= ack_take ? HOLDOFF_INIT : holdoff - ((holdoff != 2'd0) ? 2'd1 : 2'd0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Core status copy, transfer start and event interrupt
   wire logic exc_take = ack_take & ~accept.to_xfer;
   wire logic xfr_take = ack_take & accept.to_xfer;
   wire logic sr_write = wr_now & (dp_addr == OFS_CORE_SR);
   wire logic [EV_W-1:0] ev_set;

   assign ev_set = {|pin_set, xfr_take, exc_take};
   assign irq    = |(ev_status & ev_mask);

   always_ff @(posedge clk) begin
      if (rst) begin
         sr_trace      <= 1'b0;
         sr_mask_level <= '0;
         xfer_start    <= 1'b0;
         ev_status     <= '0;
      end else begin
         xfer_start <= xfr_take;                                                    // R06
         // Read clears the events seen; a new event in that cycle survives
         ev_status  <= ev_set | (ev_status & ~(rd_ev ? ev_status : '0));
         if (exc_take) begin
            sr_trace      <= 1'b0;                                                  // R07
            sr_mask_level <= accept.level;                                          // R07
         end else if (sr_write) begin
            sr_trace      <= hwdata[SR_TRACE_BIT];
            sr_mask_level <= hwdata[SR_MASK_LSB +: LVL_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_exc_ack;
      core_ack && accept.valid && !accept.to_xfer;
   endsequence
   sequence s_sr_loaded;
      !sr_trace && sr_mask_level == $past(accept.level);
   endsequence

   property p_flag_set;
      @(posedge clk) disable iff (rst) pin_fall[1] && pin_en[1] |=> pin_flag[1];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("enabled edge did not set flag"); // R01

   property p_auto_clear;
      @(posedge clk) disable iff (rst)
         core_ack && accept.valid && accept.idx == 6'h01 && !pin_set[1] |=> !pin_flag[1];
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("ack left pin flag set"); // R02

   property p_sw_clear;
      @(posedge clk) disable iff (rst)
         wr_flags && pin_armed[0] && !wr_byte[1] && !pin_set[0] |=> !pin_flag[0];
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("read-write zero missed"); // R03

   property p_write_one;
      @(posedge clk) disable iff (rst)
         !pin_flag[0] && !pin_set[0] |=> !pin_flag[0];
   endproperty
   a_write_one: assert property (p_write_one) else $error("flag set without edge"); // R03

   property p_bit0_one;
      @(posedge clk) disable iff (rst) rd_flags |=> hrdata[0] && hrdata[7:4] == 4'hF;
   endproperty
   a_bit0_one: assert property (p_bit0_one) else $error("reserved flag bits not one"); // R04

   property p_exc_sr;
      @(posedge clk) disable iff (rst) s_exc_ack |=> s_sr_loaded;
   endproperty
   a_exc_sr: assert property (p_exc_sr) else $error("trace or mask not loaded"); // R07

   property p_xfer;
      @(posedge clk) disable iff (rst)
         core_ack && accept.valid && accept.to_xfer |=> xfer_start ##1 !xfer_start;
   endproperty
   a_xfer: assert property (p_xfer) else $error("transfer start not one pulse"); // R06

   property p_above_mask;
      @(posedge clk) disable iff (rst) accept.valid |-> accept.level > $past(sr_mask_level);
   endproperty
   a_above_mask: assert property (p_above_mask) else $error("offered at or below mask"); // R17

   property p_pri_reset;
      @(posedge clk) rst |=> pri_field[0] == 3'h0 && pri_field[NUM_FIELDS-1] == 3'h0;
   endproperty
   a_pri_reset: assert property (p_pri_reset) else $error("priority not cleared by reset"); // R08

   property p_two_cycle;
      @(posedge clk) disable iff (rst)
         accept.valid |-> |($past(pend_raw, 2) & (NUM_SRC'(1) << accept.idx));
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("offer without two-cycle cause"); // R14
endmodule // irq_flags_and_priority_unit

// File: rtl/irq_pkg.sv
// Shared constants, types and source mapping of the interrupt flag and priority unit
package irq_pkg;
   // Source counts and widths
   localparam int NUM_PINS     = 3;
   localparam int NUM_INTERNAL = 39;
   localparam int NUM_SRC      = NUM_PINS + NUM_INTERNAL;
   localparam int NUM_PRI      = 6;
   localparam int NUM_FIELDS   = 2 * NUM_PRI;
   localparam int LVL_W        = 3;
   localparam int IDX_W        = 6;
   localparam int FLD_W        = 4;
   localparam int EV_W         = 3;

   // Register byte offsets
   localparam logic [7:0] OFS_FLAGS     = 8'h00;
   localparam logic [7:0] OFS_PRI_BASE  = 8'h04;
   localparam logic [7:0] OFS_PIN_EN    = 8'h1C;
   localparam logic [7:0] OFS_XFER_LO   = 8'h20;
   localparam logic [7:0] OFS_XFER_HI   = 8'h24;
   localparam logic [7:0] OFS_CORE_SR   = 8'h28;
   localparam logic [7:0] OFS_EV_STATUS = 8'h2C;
   localparam logic [7:0] OFS_EV_MASK   = 8'h30;

   // Field layouts and reset values
   localparam logic [7:0] FLAGS_ONES    = 8'hF1;
   localparam int         FLAG_LSB      = 1;
   localparam int         PRI_UPPER_LSB = 4;
   localparam int         PRI_LOWER_LSB = 0;
   localparam logic [7:0] PRI_RESET     = 8'h00;
   localparam int         SR_TRACE_BIT  = 7;
   localparam int         SR_MASK_LSB   = 0;
   localparam int         XFER_HI_W     = NUM_SRC - 32;
   localparam int         EV_CORE       = 0;
   localparam int         EV_XFER       = 1;
   localparam int         EV_PIN        = 2;

   // Timing: priority decision takes this many system clock cycles
   localparam int         PRIO_CYCLES   = 2;
   localparam logic [1:0] HOLDOFF_INIT  = 2'(PRIO_CYCLES);

   typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_e;

   // Request handed to the core
   typedef struct packed {
      logic             valid;
      logic             to_xfer;
      logic [IDX_W-1:0] idx;
      logic [LVL_W-1:0] level;
   } accept_req_s;

   // Level field index of each source: pins share one field, internal
   // sources fill the remaining fields in order
   function automatic logic [FLD_W-1:0] field_of(input int src);
      int j;
      j = src - NUM_PINS;
      if (src < NUM_PINS) begin
         field_of = 4'h1;
      end else if (j < 2) begin
         field_of = 4'h0;
      end else if (((j - 2) / 4) + 2 > NUM_FIELDS - 1) begin
         field_of = 4'(NUM_FIELDS - 1);
      end else begin
         field_of = 4'(((j - 2) / 4) + 2);
      end
   endfunction
endpackage

// File: rtl/pin_fall_detect.sv
// Synchronises active-low request pins and flags their falling edges
`timescale 1ns/1ps
module pin_fall_detect import irq_pkg::*; #(
   parameter int N = 3
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pins and edge pulses
   input  wire logic [N-1:0] pin_n,
   output logic      [N-1:0] fall
);
   logic [N-1:0] sync_a;
   logic [N-1:0] sync_b;
   logic [N-1:0] sync_c;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         // Idle pins are high; reset to high so no edge is seen at release
         always_ff @(posedge clk) begin
            if (rst) begin
               sync_a[g] <= 1'b1;
               sync_b[g] <= 1'b1;
               sync_c[g] <= 1'b1;
            end else begin
               sync_a[g] <= pin_n[g];
               sync_b[g] <= sync_a[g];
               sync_c[g] <= sync_b[g];
            end
         end
         assign fall[g] = sync_c[g] & ~sync_b[g];
      end
   endgenerate
endmodule // pin_fall_detect
